// ---- core/pir_pkg.sv ----
// shared constants and types for the identity, revision and compensation register bank
package pir_pkg;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_COMM = 8'h7e;
    localparam logic [7:0] CMD_PART_IDENTITY = 8'had;
    localparam logic [7:0] CMD_SILICON_REVISION = 8'hae;
    localparam logic [7:0] CMD_LOOP_COMPENSATION = 8'hb1;

    // ****************************************
    // byte counts, bit positions, reset values
    // ****************************************
    localparam logic [7:0] ID_BYTES = 8'h06;
    localparam logic [7:0] REV_BYTES = 8'h02;
    localparam logic [7:0] COMP_BYTES = 8'h05;
    localparam logic [7:0] PLAIN_BYTES = 8'h01;
    localparam int STATUS_BYTE_COMM_BIT = 1;
    localparam int STATUS_COMM_INVALID_BIT = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] IDLE_FILL = 8'hff;
    localparam logic [7:0] CMD_RESET = 8'h00;

    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic [3:0] revision_major_field;
        logic [3:0] revision_middle_field;
        logic [7:0] revision_lowest_field;
    } pir_rev_t;

    // compensation word as stored, msb first
    typedef struct packed {
        logic [1:0] czi_low;
        logic [4:0] current_filter_cap_sel;
        logic current_integrator_doubler;
        logic [5:0] current_gain_resistor_sel;
        logic [1:0] czi_high;
        logic [1:0] czv_low;
        logic [4:0] voltage_filter_cap_sel;
        logic rsv_16;
        logic [5:0] voltage_gain_resistor_sel;
        logic [1:0] czv_high;
        logic [1:0] rsv_7_6;
        logic [1:0] voltage_transconductance_sel;
        logic [1:0] rsv_3_2;
        logic [1:0] current_transconductance_sel;
    } pir_comp_t;

    // selectors handed to the analog loop
    typedef struct packed {
        logic [3:0] current_integrator_cap_sel;
        logic [4:0] current_filter_cap_sel;
        logic current_integrator_doubler;
        logic [5:0] current_gain_resistor_sel;
        logic [3:0] voltage_integrator_cap_sel;
        logic [4:0] voltage_filter_cap_sel;
        logic [5:0] voltage_gain_resistor_sel;
        logic [1:0] voltage_transconductance_sel;
        logic [1:0] current_transconductance_sel;
    } pir_loop_t;

    // one-cycle events from the byte layer
    typedef struct packed {
        logic addr_hit;
        logic addr_read;
        logic rx_valid;
        logic [7:0] rx_byte;
        logic tx_taken;
        logic stop;
    } pir_link_ev_t;

endpackage

// ---- core/pir_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pir_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } pir_sync_t;

    pir_sync_t st;
    pir_sync_t next_st;

    // idle bus level is high, so reset to ones
    always_comb begin
        next_st.meta = din;
        next_st.held = st.meta;
        if (rst) begin
            next_st = '1;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign dout = st.held;
endmodule // pir_sync

// ---- core/pir_byte_link.sv ----
// bus byte layer: start/stop, address match, byte receive with ack, byte send
`timescale 1ns/1ps
module pir_byte_link
    import pir_pkg::*;
#(
    parameter logic [6:0] ADDRESS = 7'h10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] tx_byte,
    output pir_link_ev_t ev,
    output logic drive_low
);
    typedef enum logic [2:0] {
        L_IDLE = 3'h0,
        L_RX = 3'h1,
        L_ACK = 3'h3,
        L_TX = 3'h2,
        L_RACK = 3'h6
    } pir_lstate_t;

    typedef struct packed {
        pir_lstate_t state;
        logic scl_d;
        logic sda_d;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic first;
        logic rd;
        logic drive;
        logic nack;
        pir_link_ev_t ev;
    } pir_link_t;

    pir_link_t st;
    pir_link_t next_st;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    always_comb begin
        rise = scl & ~st.scl_d;
        fall = ~scl & st.scl_d;
        start = scl & st.scl_d & st.sda_d & ~sda;
        stop = scl & st.scl_d & ~st.sda_d & sda;
        next_st = st;
        next_st.ev = '0;
        next_st.scl_d = scl;
        next_st.sda_d = sda;
        case (st.state)
            L_RX: begin
                if (rise && st.cnt != 4'h8) begin
                    next_st.sh = {st.sh[6:0], sda};
                    next_st.cnt = st.cnt + 4'h1;
                end else if (fall && st.cnt == 4'h8) begin
                    if (st.first) begin
                        // foreign address: stay off the bus until the next start
                        if (st.sh[7:1] == ADDRESS) begin
                            next_st.ev.addr_hit = 1'b1;
                            next_st.ev.addr_read = st.sh[0];
                            next_st.rd = st.sh[0];
                            next_st.state = L_ACK;
                            next_st.drive = 1'b1;
                        end else begin
                            next_st.state = L_IDLE;
                        end
                    end else begin
                        next_st.ev.rx_valid = 1'b1;
                        next_st.ev.rx_byte = st.sh;
                        next_st.state = L_ACK;
                        next_st.drive = 1'b1;
                    end
                end
            end
            L_ACK: begin
                if (fall) begin
                    next_st.first = 1'b0;
                    next_st.cnt = 4'h0;
                    if (st.rd) begin
                        next_st.sh = tx_byte;
                        next_st.drive = ~tx_byte[7];
                        next_st.ev.tx_taken = 1'b1;
                        next_st.state = L_TX;
                    end else begin
                        next_st.drive = 1'b0;
                        next_st.state = L_RX;
                    end
                end
            end
            L_TX: begin
                if (fall) begin
                    if (st.cnt == 4'h7) begin
                        next_st.drive = 1'b0;
                        next_st.state = L_RACK;
                    end else begin
                        next_st.sh = {st.sh[6:0], 1'b0};
                        next_st.drive = ~st.sh[6];
                        next_st.cnt = st.cnt + 4'h1;
                    end
                end
            end
            L_RACK: begin
                if (rise) begin
                    next_st.nack = sda;
                end else if (fall) begin
                    if (st.nack) begin
                        next_st.state = L_IDLE;
                    end else begin
                        next_st.sh = tx_byte;
                        next_st.drive = ~tx_byte[7];
                        next_st.cnt = 4'h0;
                        next_st.ev.tx_taken = 1'b1;
                        next_st.state = L_TX;
                    end
                end
            end
            default: begin
                next_st.drive = 1'b0;
            end
        endcase
        if (start) begin
            next_st.state = L_RX;
            next_st.cnt = 4'h0;
            next_st.first = 1'b1;
            next_st.drive = 1'b0;
        end else if (stop) begin
            next_st.state = L_IDLE;
            next_st.drive = 1'b0;
            next_st.ev.stop = 1'b1;
        end
        if (rst) begin
            next_st = '0;
            next_st.scl_d = 1'b1;
            next_st.sda_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign ev = st.ev;
    assign drive_low = st.drive;
endmodule // pir_byte_link

// ---- core/pir_regs.sv ----
// identity, revision and loop compensation command registers behind the bus pins
`timescale 1ns/1ps
module pir_regs
    import pir_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDRESS = 7'h10,
    // arbitrary neutral value
    parameter logic [47:0] PART_IDENTITY = 48'h0000_0000_0001,
    // arbitrary neutral value
    parameter pir_rev_t SILICON_REVISION = 16'h1000
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic ALERT_OUT,
    output logic ALERT_OE,
    input wire logic CONVERSION_ENABLED,
    input wire logic RESTORE_PULSE,
    input wire logic STRAP_OVERRIDE,
    input wire logic [39:0] NVM_WORD,
    input wire logic [39:0] STRAP_WORD,
    output logic [39:0] STORED_WORD,
    output logic [39:0] APPLIED_WORD,
    output pir_loop_t LOOP_SETTINGS,
    output logic INVALID_COMMAND
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_CMD = 3'h1,
        PH_COUNT = 3'h3,
        PH_DATA = 3'h2,
        PH_READ = 3'h6,
        PH_SKIP = 3'h7
    } pir_phase_t;

    typedef struct packed {
        pir_phase_t phase;
        logic [7:0] cmd;
        logic [3:0] idx;
        logic [7:0] wcount;
        logic [39:0] stage;
        logic [39:0] stored;
        logic [39:0] applied;
        logic [7:0] status_byte;
        logic [7:0] status_comm;
        logic clear_pend;
        logic [7:0] tx_byte;
    } pir_regs_t;

    pir_regs_t st;
    pir_regs_t next_st;
    logic scl_s;
    logic sda_s;
    pir_link_ev_t ev;
    logic drive_low;
    logic [39:0] src;
    logic set_invalid;
    pir_comp_t aw;

    // ****************************************
    // pins and byte layer
    // ****************************************
    pir_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(CLOCK),
        .rst(RESET),
        .din({SCL, SDA_IN}),
        .dout({scl_s, sda_s})
    );

    pir_byte_link #(
        .ADDRESS(DEVICE_ADDRESS)
    ) u_link (
        .clk(CLOCK),
        .rst(RESET),
        .scl(scl_s),
        .sda(sda_s),
        .tx_byte(st.tx_byte),
        .ev(ev),
        .drive_low(drive_low)
    );

    // ****************************************
    // read data selection
    // ****************************************
    // byte the host gets at position idx of the current read
    function automatic logic [7:0] pick(input pir_regs_t s);
        logic [47:0] v;
        logic [7:0] n;
        logic blk;
        logic [3:0] k;
        v = '0;
        n = 8'h00;
        blk = 1'b1;
        case (s.cmd)
            CMD_PART_IDENTITY: begin
                v = PART_IDENTITY;
                n = ID_BYTES;
            end
            CMD_SILICON_REVISION: begin
                v = {32'h0000_0000, SILICON_REVISION};
                n = REV_BYTES;
            end
            CMD_LOOP_COMPENSATION: begin
                v = {8'h00, s.stored};
                n = COMP_BYTES;
            end
            CMD_STATUS_BYTE: begin
                v = {40'h00_0000_0000, s.status_byte};
                n = PLAIN_BYTES;
                blk = 1'b0;
            end
            CMD_STATUS_COMM: begin
                v = {40'h00_0000_0000, s.status_comm};
                n = PLAIN_BYTES;
                blk = 1'b0;
            end
            default: begin
                v = '0;
            end
        endcase
        k = blk ? s.idx - 4'h1 : s.idx;
        if (blk && s.idx == 4'h0) begin
            pick = n;
        end else if ({4'h0, k} < n) begin
            pick = v[{k[2:0], 3'b000} +: 8];
        end else begin
            pick = IDLE_FILL;
        end
    endfunction

    // ****************************************
    // transaction handling
    // ****************************************
    always_comb begin
        next_st = st;
        set_invalid = 1'b0;
        // override set means strap detection wins over stored memory
        src = STRAP_OVERRIDE ? STRAP_WORD : NVM_WORD;

        if (ev.addr_hit) begin
            if (ev.addr_read) begin
                next_st.phase = PH_READ;
                next_st.idx = 4'h0;
            end else begin
                next_st.phase = PH_CMD;
                next_st.idx = 4'h0;
            end
        end

        if (ev.rx_valid) begin
            case (st.phase)
                PH_CMD: begin
                    next_st.cmd = ev.rx_byte;
                    next_st.clear_pend = (ev.rx_byte == CMD_CLEAR_FAULTS);
                    if (ev.rx_byte == CMD_LOOP_COMPENSATION) begin
                        next_st.phase = PH_COUNT;
                    end else begin
                        next_st.phase = PH_SKIP;
                    end
                end
                PH_SKIP: begin
                    // data under a command with no write form
                    next_st.clear_pend = 1'b0;
                    set_invalid = 1'b1;
                end
                PH_COUNT: begin
                    next_st.wcount = ev.rx_byte;
                    next_st.idx = 4'h0;
                    next_st.phase = PH_DATA;
                end
                PH_DATA: begin
                    // reserved bits are stored as sent; keeping them zero is up to the host
                    if ({4'h0, st.idx} < COMP_BYTES) begin
                        next_st.stage[{st.idx[2:0], 3'b000} +: 8] = ev.rx_byte;
                    end
                    if (st.idx != 4'hf) begin
                        next_st.idx = st.idx + 4'h1;
                    end
                end
                default: begin
                    next_st.phase = st.phase;
                end
            endcase
        end

        if (ev.tx_taken && st.phase == PH_READ && st.idx != 4'hf) begin
            next_st.idx = st.idx + 4'h1;
        end

        if (ev.stop) begin
            // a short or long block is dropped whole so a torn word never reaches the loop
            if (st.phase == PH_DATA && st.wcount == COMP_BYTES
                    && {4'h0, st.idx} == COMP_BYTES) begin
                next_st.stored = st.stage;
                if (!CONVERSION_ENABLED) begin
                    next_st.applied = st.stage;
                end
            end
            if (st.phase == PH_SKIP && st.clear_pend) begin
                next_st.status_byte = STATUS_RESET;
                next_st.status_comm = STATUS_RESET;
            end
            next_st.phase = PH_IDLE;
            next_st.clear_pend = 1'b0;
        end

        // set after clear so a fault in the clearing cycle survives
        if (set_invalid) begin
            next_st.status_comm[STATUS_COMM_INVALID_BIT] = 1'b1;
            next_st.status_byte[STATUS_BYTE_COMM_BIT] = 1'b1;
        end

        // reload path used after a save and override change by the host
        if (RESTORE_PULSE) begin
            next_st.stored = src;
            next_st.applied = src;
        end

        next_st.tx_byte = pick(next_st);

        if (RESET) begin
            next_st.phase = PH_IDLE;
            next_st.cmd = CMD_RESET;
            next_st.idx = 4'h0;
            next_st.wcount = 8'h00;
            next_st.stage = '0;
            next_st.stored = src;
            next_st.applied = src;
            next_st.status_byte = STATUS_RESET;
            next_st.status_comm = STATUS_RESET;
            next_st.clear_pend = 1'b0;
            next_st.tx_byte = IDLE_FILL;
        end
    end

    always_ff @(posedge CLOCK) begin
        st <= next_st;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign aw = st.applied;

    always_comb begin
        LOOP_SETTINGS.current_integrator_cap_sel = {aw.czi_high, aw.czi_low};
        LOOP_SETTINGS.current_filter_cap_sel = aw.current_filter_cap_sel;
        LOOP_SETTINGS.current_integrator_doubler = aw.current_integrator_doubler;
        LOOP_SETTINGS.current_gain_resistor_sel = aw.current_gain_resistor_sel;
        LOOP_SETTINGS.voltage_integrator_cap_sel = {aw.czv_high, aw.czv_low};
        LOOP_SETTINGS.voltage_filter_cap_sel = aw.voltage_filter_cap_sel;
        LOOP_SETTINGS.voltage_gain_resistor_sel = aw.voltage_gain_resistor_sel;
        LOOP_SETTINGS.voltage_transconductance_sel = aw.voltage_transconductance_sel;
        // also scales the current integrator capacitance in the analog loop
        LOOP_SETTINGS.current_transconductance_sel = aw.current_transconductance_sel;
    end

    // open-drain pins: only ever pull low
    assign SDA_OUT = 1'b0;
    assign SDA_OE = drive_low;
    assign ALERT_OUT = 1'b0;
    assign ALERT_OE = st.status_comm[STATUS_COMM_INVALID_BIT];
    assign INVALID_COMMAND = st.status_comm[STATUS_COMM_INVALID_BIT];
    assign STORED_WORD = st.stored;
    assign APPLIED_WORD = st.applied;
endmodule // pir_regs

// ---- bench/pir_regs_properties.sv ----
// checker for the register bank
`timescale 1ns/1ps
module pir_regs_properties
    import pir_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic SCL,
    input wire logic SDA_IN,
    input wire logic SDA_OE,
    input wire logic ALERT_OE,
    input wire logic CONVERSION_ENABLED,
    input wire logic RESTORE_PULSE,
    input wire logic STRAP_OVERRIDE,
    input wire logic [39:0] NVM_WORD,
    input wire logic [39:0] STRAP_WORD,
    input wire logic [39:0] STORED_WORD,
    input wire logic [39:0] APPLIED_WORD,
    input wire pir_loop_t LOOP_SETTINGS,
    input wire logic INVALID_COMMAND
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // ********
    // selector wiring
    // ********
    chk_czi_split: assert property (LOOP_SETTINGS.current_integrator_cap_sel ==
        {APPLIED_WORD[25:24], APPLIED_WORD[39:38]}) else $error("current cap select wrong");
    chk_cpi_doubler: assert property ({LOOP_SETTINGS.current_filter_cap_sel,
        LOOP_SETTINGS.current_integrator_doubler} == APPLIED_WORD[37:32])
        else $error("current filter or doubler wrong");
    chk_rvi_field: assert property (LOOP_SETTINGS.current_gain_resistor_sel ==
        APPLIED_WORD[31:26]) else $error("current gain select wrong");
    chk_czv_split: assert property (LOOP_SETTINGS.voltage_integrator_cap_sel ==
        {APPLIED_WORD[9:8], APPLIED_WORD[23:22]}) else $error("voltage cap select wrong");
    chk_voltage_fields: assert property ({LOOP_SETTINGS.voltage_filter_cap_sel,
        LOOP_SETTINGS.voltage_gain_resistor_sel} == {APPLIED_WORD[21:17], APPLIED_WORD[15:10]})
        else $error("voltage filter or gain wrong");
    chk_gm_fields: assert property ({LOOP_SETTINGS.voltage_transconductance_sel,
        LOOP_SETTINGS.current_transconductance_sel} == {APPLIED_WORD[5:4], APPLIED_WORD[1:0]})
        else $error("gm selects wrong");
    // ********
    // update and fault timing
    // ********
    chk_apply_off: assert property ($changed(STORED_WORD) && !$past(CONVERSION_ENABLED) &&
        !$past(RESTORE_PULSE) |-> APPLIED_WORD == STORED_WORD) else $error("word not applied");
    chk_hold_on: assert property (CONVERSION_ENABLED && !RESTORE_PULSE |=>
        $stable(APPLIED_WORD)) else $error("applied word moved");
    chk_reload_src: assert property (RESTORE_PULSE |=> APPLIED_WORD ==
        ($past(STRAP_OVERRIDE) ? $past(STRAP_WORD) : $past(NVM_WORD)))
        else $error("reload took wrong source");
    chk_alert_flag: assert property (ALERT_OE == INVALID_COMMAND)
        else $error("alert does not follow flag");
    chk_flag_ack: assert property ($rose(INVALID_COMMAND) |-> SDA_OE)
        else $error("flag rose outside ack");
    chk_flag_clear: assert property (!$past(RESET) && $fell(INVALID_COMMAND) |->
        SCL && SDA_IN && !SDA_OE) else $error("flag cleared outside stop");
    cov_fault: cover property ($rose(INVALID_COMMAND));
    cov_store_running: cover property (CONVERSION_ENABLED && $changed(STORED_WORD));
    cov_strap_reload: cover property (RESTORE_PULSE && STRAP_OVERRIDE);
endmodule // pir_regs_properties

// ---- bench/pir_host_model.sv ----
// bus host model on an open-drain pair
`timescale 1ns/1ps
module pir_host_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // 10-cycle half periods cover the 3-cycle pin delay
    task automatic clock_bit(input logic b, output logic seen);
        sda_pull = ~b;
        wait_cycles(5);
        scl = 1'b1;
        wait_cycles(5);
        seen = sda;
        wait_cycles(5);
        scl = 1'b0;
        wait_cycles(5);
    endtask
    // also serves as repeated start
    task automatic start_cond();
        sda_pull = 1'b0;
        wait_cycles(5);
        scl = 1'b1;
        wait_cycles(10);
        sda_pull = 1'b1;
        wait_cycles(10);
        scl = 1'b0;
        wait_cycles(5);
    endtask
    task automatic stop_cond();
        sda_pull = 1'b1;
        wait_cycles(5);
        scl = 1'b1;
        wait_cycles(10);
        sda_pull = 1'b0;
        wait_cycles(10);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], seen);
        clock_bit(1'b1, seen);
        ack = ~seen;
    endtask
    // nack the last byte so the device lets go
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
        clock_bit(last, seen);
    endtask
endmodule // pir_host_model

// ---- bench/tb_pir_regs.sv ----
// self-checking bench for the register bank
`timescale 1ns/1ps
module tb_pir_regs;
    import pir_pkg::*;
    localparam logic [6:0] ADDR = 7'h10;
    // arbitrary values
    localparam logic [47:0] ID_VALUE = 48'ha1b2_c3d4_e5f6;
    localparam logic [15:0] REV_VALUE = 16'h357c;
    // reserved bits kept zero
    localparam logic [39:0] W1 = 40'hb6_9ae2_b831;
    localparam logic [39:0] W2 = 40'h4c_155c_d412;
    logic CLOCK, RESET, SCL, sda_pull, CONVERSION_ENABLED, RESTORE_PULSE, STRAP_OVERRIDE;
    logic SDA_OUT, SDA_OE, ALERT_OUT, ALERT_OE, INVALID_COMMAND;
    logic [39:0] NVM_WORD, STRAP_WORD, STORED_WORD, APPLIED_WORD;
    pir_loop_t LOOP_SETTINGS;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // pull-up holds the line high
    wire sda_line = ~(sda_pull | SDA_OE);
    pir_regs #(.DEVICE_ADDRESS(ADDR), .PART_IDENTITY(ID_VALUE), .SILICON_REVISION(REV_VALUE))
    pir_regs_inst (.CLOCK(CLOCK), .RESET(RESET), .SCL(SCL), .SDA_IN(sda_line),
        .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ALERT_OUT(ALERT_OUT), .ALERT_OE(ALERT_OE),
        .CONVERSION_ENABLED(CONVERSION_ENABLED), .RESTORE_PULSE(RESTORE_PULSE),
        .STRAP_OVERRIDE(STRAP_OVERRIDE), .NVM_WORD(NVM_WORD), .STRAP_WORD(STRAP_WORD),
        .STORED_WORD(STORED_WORD), .APPLIED_WORD(APPLIED_WORD),
        .LOOP_SETTINGS(LOOP_SETTINGS), .INVALID_COMMAND(INVALID_COMMAND));
    pir_host_model pir_host_model_inst (.clk(CLOCK), .sda(sda_line), .scl(SCL),
        .sda_pull(sda_pull));
    initial begin
        CLOCK = 1'b0;
        forever #2 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic write_cmd(input logic [7:0] cmd, input int n, input logic [39:0] data);
        logic ack;
        pir_host_model_inst.start_cond();
        pir_host_model_inst.send_byte({ADDR, 1'b0}, ack);
        check(ack, 1'b1);
        pir_host_model_inst.send_byte(cmd, ack);
        if (cmd == CMD_LOOP_COMPENSATION) pir_host_model_inst.send_byte(8'(n), ack);
        for (int i = 0; i < n; i++) pir_host_model_inst.send_byte(data[8*i +: 8], ack);
        pir_host_model_inst.stop_cond();
    endtask
    task automatic read_cmd(input logic [7:0] cmd, input int n, output logic [55:0] got);
        logic ack;
        got = '0;
        pir_host_model_inst.start_cond();
        pir_host_model_inst.send_byte({ADDR, 1'b0}, ack);
        pir_host_model_inst.send_byte(cmd, ack);
        pir_host_model_inst.start_cond();
        pir_host_model_inst.send_byte({ADDR, 1'b1}, ack);
        for (int i = 0; i < n; i++) pir_host_model_inst.recv_byte(i == n - 1, got[8*i +: 8]);
        pir_host_model_inst.stop_cond();
    endtask
    task automatic pulse_restore();
        @(posedge CLOCK) #1 RESTORE_PULSE = 1'b1;
        @(posedge CLOCK) #1 RESTORE_PULSE = 1'b0;
    endtask
    task automatic test_read_only();
        logic [55:0] got;
        check(APPLIED_WORD, NVM_WORD);
        read_cmd(CMD_PART_IDENTITY, 7, got);
        check(got, {ID_VALUE, 8'h06});
        read_cmd(CMD_SILICON_REVISION, 3, got);
        check(got, {REV_VALUE, 8'h02});
        $display("read-only test done");
    endtask
    task automatic test_write_off();
        logic [55:0] got;
        pir_loop_t exp;
        write_cmd(CMD_LOOP_COMPENSATION, 5, W1);
        check(STORED_WORD, W1);
        check(APPLIED_WORD, W1);
        exp = {W1[25:24], W1[39:38], W1[37:33], W1[32], W1[31:26], W1[9:8], W1[23:22],
            W1[21:17], W1[15:10], W1[5:4], W1[1:0]};
        check(LOOP_SETTINGS, exp);
        read_cmd(CMD_LOOP_COMPENSATION, 6, got);
        check(got, {W1, 8'h05});
        // a short block is dropped
        write_cmd(CMD_LOOP_COMPENSATION, 4, W2);
        check(STORED_WORD, W1);
        $display("write off test done");
    endtask
    task automatic test_write_on();
        CONVERSION_ENABLED = 1'b1;
        write_cmd(CMD_LOOP_COMPENSATION, 5, W2);
        check(STORED_WORD, W2);
        check(APPLIED_WORD, W1);
        // save, clear override, reload
        NVM_WORD = W2;
        STRAP_OVERRIDE = 1'b0;
        pulse_restore();
        check(APPLIED_WORD, W2);
        STRAP_OVERRIDE = 1'b1;
        pulse_restore();
        check(APPLIED_WORD, STRAP_WORD);
        CONVERSION_ENABLED = 1'b0;
        $display("write on test done");
    endtask
    task automatic test_invalid();
        logic [55:0] got;
        logic [7:0] cmds [2] = '{CMD_PART_IDENTITY, CMD_SILICON_REVISION};
        foreach (cmds[k]) begin
            write_cmd(cmds[k], 1, 40'h12);
            check(INVALID_COMMAND, 1'b1);
            check(ALERT_OE, 1'b1);
            read_cmd(CMD_STATUS_COMM, 1, got);
            check(got[STATUS_COMM_INVALID_BIT], 1'b1);
            read_cmd(CMD_STATUS_BYTE, 1, got);
            check(got[STATUS_BYTE_COMM_BIT], 1'b1);
            write_cmd(CMD_CLEAR_FAULTS, 0, 40'h0);
            check({INVALID_COMMAND, ALERT_OE, SDA_OUT, ALERT_OUT}, 4'h0);
        end
        read_cmd(CMD_PART_IDENTITY, 7, got);
        check(got, {ID_VALUE, 8'h06});
        $display("invalid write test done");
    endtask
    initial begin
        RESET = 1'b1;
        CONVERSION_ENABLED = 1'b0;
        RESTORE_PULSE = 1'b0;
        STRAP_OVERRIDE = 1'b0;
        NVM_WORD = 40'h11_2233_4400;
        STRAP_WORD = 40'h82_0c41_0030;
        repeat (10) @(posedge CLOCK);
        #1 RESET = 1'b0;
        repeat (4) @(posedge CLOCK);
        #1;
        test_read_only();
        test_write_off();
        test_write_on();
        test_invalid();
        complete_run();
    end
endmodule // tb_pir_regs
bind pir_regs pir_regs_properties pir_regs_properties_inst (.CLOCK(CLOCK), .RESET(RESET),
    .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OE(SDA_OE), .ALERT_OE(ALERT_OE),
    .CONVERSION_ENABLED(CONVERSION_ENABLED), .RESTORE_PULSE(RESTORE_PULSE),
    .STRAP_OVERRIDE(STRAP_OVERRIDE), .NVM_WORD(NVM_WORD), .STRAP_WORD(STRAP_WORD),
    .STORED_WORD(STORED_WORD), .APPLIED_WORD(APPLIED_WORD),
    .LOOP_SETTINGS(LOOP_SETTINGS), .INVALID_COMMAND(INVALID_COMMAND));
